// *** src/uart_host_bus_interface.sv ***
`timescale 1ns/1ps
module uart_host_bus_interface
	import host_port_pkg::*;
#(
	parameter int DW = host_port_pkg::DATA_W,
	parameter int AW = host_port_pkg::ADDR_W
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic clk_en_i,
	input wire logic [host_port_pkg::ADDR_W-1:0] reg_select_i,
	input wire logic chip_sel_first_high_i,
	input wire logic chip_sel_second_high_i,
	input wire logic chip_sel_third_low_n_i,
	input wire logic read_strobe_high_i,
	input wire logic read_strobe_low_n_i,
	input wire logic write_strobe_high_i,
	input wire logic write_strobe_low_n_i,
	input wire logic address_latch_strobe_i,
	input wire logic [host_port_pkg::DATA_W-1:0] host_data_bus_i,
	output logic [host_port_pkg::DATA_W-1:0] host_data_bus_o,
	output logic host_data_bus_oe_n_o,
	output logic drive_disable_out_n_o,
	output logic [host_port_pkg::ADDR_W-1:0] reg_rd_addr_o,
	input wire logic [host_port_pkg::DATA_W-1:0] reg_rd_data_i,
	output logic reg_rd_done_o,
	output logic reg_wr_o,
	output logic [host_port_pkg::ADDR_W-1:0] reg_wr_addr_o,
	output logic [host_port_pkg::DATA_W-1:0] reg_wr_data_o
);
	import host_port_pkg::*;

	pin_sync_if #(.WIDTH(PIN_W)) sync_bus ();

	logic [PIN_W-1:0] raw_pins;
	logic [PIN_W-1:0] pins;
	logic [AW-1:0] live_addr;
	logic [2:0] live_cs;
	logic as_high;
	logic [AW-1:0] lat_addr_r;
	logic [2:0] lat_cs_r;
	logic [AW-1:0] eff_addr;
	logic [2:0] eff_cs;
	logic selected;
	logic rd_req;
	logic wr_req;
	logic rd_act;
	logic wr_act;
	logic rd_act_r;
	logic wr_act_r;
	logic [DW-1:0] rd_data_r;
	logic [AW-1:0] rd_addr_r;
	logic rd_done_r;
	logic [DW-1:0] wr_data_r;
	logic [AW-1:0] wr_addr_r;
	logic wr_pulse_r;
	logic [DW-1:0] wr_out_data_r;
	logic [AW-1:0] wr_out_addr_r;

	if (DW != DATA_W || AW != ADDR_W)
	begin : g_width_check
		$error("Host port widths are fixed by the pin map");
	end

	assign raw_pins = {address_latch_strobe_i, write_strobe_low_n_i, write_strobe_high_i,
		read_strobe_low_n_i, read_strobe_high_i, chip_sel_third_low_n_i,
		chip_sel_second_high_i, chip_sel_first_high_i, reg_select_i, host_data_bus_i};

	// Host strobes are asynchronous to clk_i, so every pin is resynchronised
	pin_sync #(
		.WIDTH(PIN_W),
		.IDLE(PIN_IDLE)
	) u_pin_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.clk_en_i(clk_en_i),
		.pins_i(raw_pins),
		.out(sync_bus.producer)
	);

	assign pins = sync_bus.level;
	assign live_addr = pins[PIN_ADDR_LSB +: AW];
	assign live_cs = {pins[PIN_CS_THIRD_N], pins[PIN_CS_SECOND], pins[PIN_CS_FIRST]};
	assign as_high = pins[PIN_AS];

	// Latch tracks live pins while the strobe is low, so it freezes on the rise
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			lat_addr_r <= ADDR_RESET;
			lat_cs_r <= ~CS_ACTIVE;
		end
		else if (clk_en_i && !as_high)
		begin
			lat_addr_r <= live_addr; // [R10]
			lat_cs_r <= live_cs; // [R10]
		end
	end

	assign eff_addr = as_high ? lat_addr_r : live_addr; // [R11] [R1]
	assign eff_cs = as_high ? lat_cs_r : live_cs; // [R11]
	assign selected = (eff_cs == CS_ACTIVE); // [R5] [R6]
	assign rd_req = pins[PIN_RD_HIGH] | ~pins[PIN_RD_LOW_N]; // [R2] [R13]
	assign wr_req = pins[PIN_WR_HIGH] | ~pins[PIN_WR_LOW_N]; // [R8] [R14]
	// Both strobes together is illegal; read is given priority so the bus stays sane
	assign rd_act = selected & rd_req; // [R16]
	assign wr_act = selected & wr_req & ~rd_req; // [R16]

	// Read path: bus driven only while a selected read strobe is active
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			rd_act_r <= 1'b0;
			rd_addr_r <= ADDR_RESET;
			rd_data_r <= DATA_RESET;
			rd_done_r <= 1'b0;
		end
		else if (clk_en_i)
		begin
			rd_act_r <= rd_act; // [R3]
			rd_addr_r <= eff_addr; // [R1]
			rd_data_r <= reg_rd_data_i; // [R12]
			// Completion pulse lets the core pop a read-side FIFO once per access
			rd_done_r <= rd_act_r & ~rd_act;
		end
	end

	// Write data is sampled while the strobe stands and committed at its end,
	// because bus data is only guaranteed stable around the trailing edge
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wr_act_r <= 1'b0;
			wr_data_r <= DATA_RESET;
			wr_addr_r <= ADDR_RESET;
		end
		else if (clk_en_i)
		begin
			wr_act_r <= wr_act;
			if (wr_act)
			begin
				wr_data_r <= pins[PIN_DATA_LSB +: DW]; // [R9]
				wr_addr_r <= eff_addr; // [R1]
			end
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wr_pulse_r <= 1'b0;
			wr_out_data_r <= DATA_RESET;
			wr_out_addr_r <= ADDR_RESET;
		end
		else if (clk_en_i)
		begin
			wr_pulse_r <= wr_act_r & ~wr_act; // [R9] [R14]
			if (wr_act_r && !wr_act)
			begin
				wr_out_data_r <= wr_data_r; // [R9]
				wr_out_addr_r <= wr_addr_r;
			end
		end
	end

	assign host_data_bus_o = rd_data_r;
	assign host_data_bus_oe_n_o = ~rd_act_r; // [R12] [R3]
	assign drive_disable_out_n_o = ~rd_act_r; // [R15]
	assign reg_rd_addr_o = rd_addr_r;
	assign reg_rd_done_o = rd_done_r;
	assign reg_wr_o = wr_pulse_r;
	assign reg_wr_addr_o = wr_out_addr_r;
	assign reg_wr_data_o = wr_out_data_r;

	a_read_drives_bus: assert property ( // [R3]
		@(posedge clk_i) disable iff (rst_i)
		(clk_en_i && rd_act) |=> !host_data_bus_oe_n_o)
		else $error("Active read did not drive the bus");

	a_idle_bus_released: assert property ( // [R12]
		@(posedge clk_i) disable iff (rst_i)
		(clk_en_i && !rd_act) |=> host_data_bus_oe_n_o)
		else $error("Bus driven without an active read");

	a_drive_disable_tracks: assert property ( // [R15]
		@(posedge clk_i) disable iff (rst_i)
		drive_disable_out_n_o == host_data_bus_oe_n_o)
		else $error("Drive disable out of step with bus drive");

	a_low_read_strobe: assert property ( // [R13]
		@(posedge clk_i) disable iff (rst_i)
		(clk_en_i && selected && !pins[PIN_RD_LOW_N]) |=> !host_data_bus_oe_n_o)
		else $error("Low read strobe ignored");

	a_high_read_strobe: assert property ( // [R2]
		@(posedge clk_i) disable iff (rst_i)
		(clk_en_i && selected && pins[PIN_RD_HIGH]) |=> !drive_disable_out_n_o)
		else $error("High read strobe ignored");

	a_deselect_ignored: assert property ( // [R16]
		@(posedge clk_i) disable iff (rst_i)
		(clk_en_i && eff_cs != CS_ACTIVE) |=> (host_data_bus_oe_n_o && !wr_act_r))
		else $error("Strobe honoured without full chip select");

	a_write_commit: assert property ( // [R9]
		@(posedge clk_i) disable iff (rst_i)
		(clk_en_i && wr_act && !pins[PIN_WR_LOW_N]) ##1 (clk_en_i && !wr_act)
		|=> (reg_wr_o && reg_wr_data_o == $past(wr_data_r)))
		else $error("Low write strobe did not commit data");

	a_high_write_strobe: assert property ( // [R8]
		@(posedge clk_i) disable iff (rst_i)
		(clk_en_i && selected && pins[PIN_WR_HIGH] && !rd_req) |=> wr_act_r)
		else $error("High write strobe ignored");

	a_write_address: assert property ( // [R1]
		@(posedge clk_i) disable iff (rst_i)
		(clk_en_i && wr_act) |=> (wr_addr_r == $past(eff_addr)))
		else $error("Write address not taken from register select");

	a_latch_on_rise: assert property ( // [R10]
		@(posedge clk_i) disable iff (rst_i)
		(clk_en_i && !as_high) ##1 as_high
		|-> (eff_addr == $past(live_addr) && eff_cs == $past(live_cs)))
		else $error("Address not frozen at latch strobe rise");

	a_latch_holds_high: assert property ( // [R10]
		@(posedge clk_i) disable iff (rst_i)
		as_high ##1 as_high |-> ($stable(eff_addr) && $stable(eff_cs)))
		else $error("Latched select changed while strobe high");

	a_live_when_low: assert property ( // [R11]
		@(posedge clk_i) disable iff (rst_i)
		(clk_en_i && !as_high && wr_act) |=> wr_addr_r == $past(live_addr))
		else $error("Live address not used with latch strobe low");
endmodule // uart_host_bus_interface

// *** src/host_port_pkg.sv ***
// Notes on behaviour
// R1: Three register-select bits choose which of eight registers an access targets.
// R2: Active-high read strobe works exactly like the active-low read strobe.
// R3: Data bus is driven toward the host only while a read strobe is active.
// R4: Board holds the high read strobe at zero when using the low one.
// R5: Logic one on the first and second chip selects means active.
// R6: Logic zero on third chip select is active; all three needed together.
// R7: Board ties every unused chip select to its active level.
// R8: Active-high write strobe works exactly like the active-low write strobe.
// R9: Either active write strobe stores bus data into the addressed register.
// R10: Rising address latch strobe freezes chip selects and register select.
// R11: Address latch strobe held low makes live selects and address used directly.
// R12: Eight-bit data bus, bit 0 least significant, driven only on reads.
// R13: Logic zero on the low read strobe requests a register read.
// R14: Logic zero on the low write strobe requests a register write.
// R15: Drive-disable output goes low while the host reads.
// R16: Strobes ignored unless all chip selects active; bus undriven, registers kept.
package host_port_pkg;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 3;
	localparam int CLK_PERIOD_NS = 20;
	// Synchronised pin vector layout
	localparam int PIN_DATA_LSB = 0;
	localparam int PIN_ADDR_LSB = 8;
	localparam int PIN_CS_FIRST = 11;
	localparam int PIN_CS_SECOND = 12;
	localparam int PIN_CS_THIRD_N = 13;
	localparam int PIN_RD_HIGH = 14;
	localparam int PIN_RD_LOW_N = 15;
	localparam int PIN_WR_HIGH = 16;
	localparam int PIN_WR_LOW_N = 17;
	localparam int PIN_AS = 18;
	localparam int PIN_W = 19;
	// Idle levels: low-active strobes and third select high, the rest low
	localparam logic [PIN_W-1:0] PIN_IDLE = 19'h2_a000;
	localparam logic [2:0] CS_ACTIVE = 3'h3;
	localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_RESET = 3'h0;
endpackage

// *** src/pin_sync_if.sv ***
`timescale 1ns/1ps
interface pin_sync_if #(parameter int WIDTH = 19);
	logic [WIDTH-1:0] level;
	modport producer (output level);
	modport consumer (input level);
endinterface

// *** src/pin_sync.sv ***
`timescale 1ns/1ps
module pin_sync #(
	parameter int WIDTH = 19,
	parameter logic [WIDTH-1:0] IDLE = '0
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic clk_en_i,
	input wire logic [WIDTH-1:0] pins_i,
	pin_sync_if.producer out
);
	logic [WIDTH-1:0] meta_r;
	logic [WIDTH-1:0] stable_r;

	if (WIDTH < 1)
	begin : g_width_check
		$error("pin_sync needs at least one pin");
	end

	// First stage is read only by the second
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			meta_r <= IDLE;
			stable_r <= IDLE;
		end
		else if (clk_en_i)
		begin
			meta_r <= pins_i;
			stable_r <= meta_r;
		end
	end

	assign out.level = stable_r;
endmodule // pin_sync

// *** testbench/core_reg_model.sv ***
`timescale 1ns/1ps
// Register core behind the host port: eight bytes, read data combinational
module core_reg_model
	import host_port_pkg::*;
#(
	parameter logic [host_port_pkg::DATA_W-1:0] INIT = 8'h00
) (
	input wire logic clk_i,
	input wire logic [host_port_pkg::ADDR_W-1:0] rd_addr_i,
	output logic [host_port_pkg::DATA_W-1:0] rd_data_o,
	input wire logic wr_i,
	input wire logic [host_port_pkg::ADDR_W-1:0] wr_addr_i,
	input wire logic [host_port_pkg::DATA_W-1:0] wr_data_i
);
	logic [DATA_W-1:0] mem_r [8];
	initial for (int i = 0; i < 8; i++) mem_r[i] = INIT;
	assign rd_data_o = mem_r[rd_addr_i];
	always @(posedge clk_i)
		if (wr_i === 1'b1) mem_r[wr_addr_i] <= wr_data_i;
endmodule // core_reg_model

// *** testbench/uart_host_bus_interface_test.sv ***
`timescale 1ns/1ps
module uart_host_bus_interface_test;
	import host_port_pkg::*;
	logic clk_i = 0;
	logic rst_i = 1;
	logic [2:0] sel = 3'h0;
	logic cs1 = 1, cs2 = 1, cs3n = 0, rdh = 0, rdl_n = 1, wrh = 0, wrl_n = 1, as = 0;
	logic [7:0] din = 8'h00;
	logic ce = 1'b1;
	logic [7:0] dout, rdat, wd, bus, wdat, q;
	logic [2:0] rad, wad, wa, ra;
	logic oe_n, dd_n, done, wr_p;
	logic [7:0] mem [8];
	int fail_count = 0;
	int cmp_count = 0;
	logic [31:0] rnd = 32'h0000_13bc;
	always #(CLK_PERIOD_NS / 2) clk_i = ~clk_i;
	// The host releases the bus during reads, so the wire shows the device
	assign bus = oe_n ? din : dout;
	uart_host_bus_interface uart_host_bus_interface_inst (.clk_i(clk_i), .rst_i(rst_i),
		.clk_en_i(ce), .reg_select_i(sel), .chip_sel_first_high_i(cs1),
		.chip_sel_second_high_i(cs2), .chip_sel_third_low_n_i(cs3n),
		.read_strobe_high_i(rdh), .read_strobe_low_n_i(rdl_n), .write_strobe_high_i(wrh),
		.write_strobe_low_n_i(wrl_n), .address_latch_strobe_i(as), .host_data_bus_i(bus),
		.host_data_bus_o(dout), .host_data_bus_oe_n_o(oe_n), .drive_disable_out_n_o(dd_n),
		.reg_rd_addr_o(rad), .reg_rd_data_i(rdat), .reg_rd_done_o(done), .reg_wr_o(wr_p),
		.reg_wr_addr_o(wad), .reg_wr_data_o(wdat));
	core_reg_model core_reg_model_inst (.clk_i(clk_i), .rd_addr_i(rad), .rd_data_o(rdat),
		.wr_i(wr_p), .wr_addr_i(wad), .wr_data_i(wdat));
	function automatic logic [31:0] xs(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	task automatic chk(input logic ok, input string m);
		cmp_count++;
		if (ok !== 1'b1)
		begin
			fail_count++;
			$display("BAD %0t %s", $time, m);
		end
	endtask
	task automatic print_verdict;
		$display("compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	// One access of any kind; lat freezes the select then scrambles the pins
	task automatic acc(input logic rd, hi, lat, input logic [2:0] a, cs);
		logic wr, drv, ddok, dn, en;
		logic [7:0] d;
		wr = 0; drv = 0; ddok = 1; dn = 0; q = 8'h00;
		rnd = xs(rnd);
		d = rnd[7:0];
		en = (cs === 3'h6);
		@(posedge clk_i);
		sel <= a; din <= d; {cs1, cs2, cs3n} <= cs; as <= 0;
		if (lat)
		begin
			repeat (3) @(posedge clk_i);
			as <= 1;
			repeat (3) @(posedge clk_i);
			sel <= ~a;
			{cs1, cs2, cs3n} <= ~cs;
		end
		@(posedge clk_i);
		if (rd) {rdh, rdl_n} <= hi ? 2'h3 : 2'h0;
		else {wrh, wrl_n} <= hi ? 2'h3 : 2'h0;
		for (int n = 0; n < 14; n++)
		begin
			@(posedge clk_i);
			if (n == 6) {rdh, rdl_n, wrh, wrl_n} <= 4'h5;
			// Data moves only after the strobe ends, so it must not reach the write
			if (n == 7) din <= ~d;
			if (n == 13) as <= 1'b0;
			#1;
			if (oe_n === 1'b0) {drv, q} = {1'b1, dout};
			if (dd_n !== oe_n) ddok = 0;
			if (done === 1'b1) dn = 1;
			if (wr_p === 1'b1) {wr, wa, wd} = {1'b1, wad, wdat};
		end
		chk(ddok, "drive disable differs from bus enable");
		chk(drv === (rd & en) && dn === (rd & en), "read drive wrong");
		chk(wr === (~rd & en), "write commit wrong");
		if (rd && en) chk(q === mem[a], "read data wrong");
		if (!rd && en) chk(wa === a && wd === d, "write addr or data wrong");
		if (!rd && en) mem[a] = d;
		$display("access rd=%0b hi=%0b lat=%0b a=%0d cs=%0h done", rd, hi, lat, a, cs);
	endtask
	// A read strobe that comes and goes while the clock enable is low is never seen
	task automatic frozen;
		logic moved;
		moved = 0;
		@(posedge clk_i);
		ce <= 1'b0;
		{rdh, rdl_n} <= 2'h0;
		for (int n = 0; n < 12; n++)
		begin
			@(posedge clk_i);
			if (n == 6) {rdh, rdl_n} <= 2'h1;
			if (n == 8) ce <= 1'b1;
			#1;
			if (oe_n !== 1'b1 || done === 1'b1 || wr_p === 1'b1) moved = 1;
		end
		chk(!moved, "state moved while clock enable low");
		$display("freeze test done");
	endtask
	initial
	begin
		for (int i = 0; i < 8; i++) mem[i] = 8'h00;
		repeat (8) @(posedge clk_i);
		rst_i <= 0;
		repeat (2) @(posedge clk_i);
		chk(oe_n === 1'b1 && dd_n === 1'b1, "bus driven after reset");
		for (int i = 0; i < 8; i++) acc(0, 0, 0, i[2:0], 3'h6);
		for (int i = 0; i < 8; i++) acc(1, 0, 0, i[2:0], 3'h6);
		frozen();
		for (int i = 0; i < 4; i++)
		begin
			rnd = xs(rnd);
			ra = rnd[2:0];
			acc(0, 1, 0, ra, 3'h6);
			acc(1, 1, 0, ra, 3'h6);
		end
		foreach (mem[i]) acc(i[0], i[2], 0, i[2:0], 3'h6 ^ (3'h1 << (i % 3)));
		for (int i = 0; i < 8; i++) acc(1, 0, 0, i[2:0], 3'h6);
		acc(0, 0, 1, 3'h5, 3'h6);
		acc(1, 0, 1, 3'h5, 3'h6);
		acc(1, 1, 0, 3'h5, 3'h6);
		print_verdict();
	end
endmodule // uart_host_bus_interface_test
